//--- rtl/prs_top.sv
// Purpose: run/stop supervisor, scan watchdog and error handling of a program engine
// Assumes: all inputs synchronous to i_clk_sys; scan strobes are one-cycle pulses
// Notes:   registers over Avalon-MM, one wait state on every access
//
// What this block does
// - master enable level selects run or stop
// - remote requests act only with master on
// - remote stop waits for scan end
// - remote run restarts at step 0
// - remote contact on means stop
// - any point X0 to X8F selectable
// - any single stop source forces stop
// - run again only when all sources run
// - stop halts program, all outputs off
// - watchdog 10 to 2000 ms, default 200
// - watchdog restarts after end processing
// - timeout on late scan or hardware fail
// - timeout: outputs off, blink, flag, code
// - diagnose at reset, instruction and end
// - stop-class error halts at once
// - continue-class error skips to next step
// - some errors stop despite continue setting
// - operation error sets flag and code
// - range conversion error code 50, selectable
// - diagnostic error flags are sticky
`timescale 1ns/1ps
`default_nettype none

module prs_top
    import prs_pkg::*;
#(
    parameter int unsigned P_TICK_CYCLES = WDT_TICK_CYCLES
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // run contacts and engine events
    input wire logic i_master_run_enable,
    input wire logic [NUM_POINTS-1:0] i_input_points,
    input wire logic i_scan_end,
    input wire logic i_end_done,
    input wire logic i_hw_fail,
    input wire logic i_init_fail,
    input wire prs_err_s i_op_err,
    input wire logic i_bcd_overflow,
    // engine control
    output logic o_engine_run,
    output logic o_restart_step0,
    output logic o_outputs_enable,
    output logic o_skip_step,
    output logic o_run_led,
    output logic o_wdt_timeout,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    localparam int unsigned PRESC_W = $clog2(P_TICK_CYCLES + 1);
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(P_TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    prs_state_e state_reg, state_next;
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [POINT_W-1:0] contact_sel_reg, contact_sel_next;
    logic [TICK_W-1:0] wdt_set_reg, wdt_set_next;
    logic diag_error_flag_reg, diag_error_flag_next;
    logic self_diag_error_flag_reg, self_diag_error_flag_next;
    logic [CODE_W-1:0] diag_error_code_reg, diag_error_code_next;
    logic wdt_to_reg, wdt_to_next;
    logic [PRESC_W-1:0] presc_reg, presc_next;
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [5:0] blink_cnt_reg, blink_cnt_next;
    logic blink_reg, blink_next;
    logic restart_reg, restart_next;
    logic skip_reg, skip_next;
    logic [31:0] rdata_reg, rdata_next;
    logic waitreq_reg, waitreq_next;
    logic contact_stop, host_stop, remote_stop, running, tick;
    logic wdt_event, self_event, op_stop, op_skip, bcd_hit;
    logic bus_req, wr_take, wr_lane0;
    logic [5:0] status_vec;

    ////////////////////////////////////////////////////////////////////////////
    // remote stop sources
    // contact point select
    // out-of-range selections read as an open contact, so they never force stop
    always_comb
    begin
        contact_stop = 1'b0;
        if (ctrl_reg[CTRL_CONTACT_EN] && contact_sel_reg <= LAST_POINT)
        begin
            contact_stop = i_input_points[contact_sel_reg];
        end
    end

    assign host_stop = ctrl_reg[CTRL_HOST_STOP];
    assign remote_stop = contact_stop | host_stop;
    assign running = (state_reg == PRS_RUN) || (state_reg == PRS_DRAIN);

    ////////////////////////////////////////////////////////////////////////////
    // self-diagnostic events
    // late scan or hardware
    assign wdt_event = running && ((tick_cnt_reg >= wdt_set_reg) || i_hw_fail);
    assign self_event = wdt_event || (state_reg == PRS_STOP && i_init_fail);
    assign op_stop = running && i_op_err.valid && (i_op_err.stop_class || i_op_err.force_stop);
    assign bcd_hit = running && i_bcd_overflow;
    assign op_skip = running && ((i_op_err.valid && !op_stop) ||
                                 (i_bcd_overflow && !ctrl_reg[CTRL_BCD_STOP]));

    ////////////////////////////////////////////////////////////////////////////
    // run/stop state machine
    always_comb
    begin
        state_next = state_reg;
        restart_next = 1'b0;
        case (state_reg)
            PRS_RUN:
            begin
                if (remote_stop)
                begin
                    state_next = PRS_DRAIN;
                end
            end
            PRS_DRAIN:
            begin
                if (i_scan_end)
                begin
                    state_next = PRS_STOP;
                end
            end
            PRS_STOP:
            begin
                if (i_master_run_enable && !remote_stop && !i_init_fail)
                begin
                    state_next = PRS_RUN;
                    restart_next = 1'b1;
                end
            end
            PRS_FAULT:
            begin
                state_next = PRS_FAULT;
            end
            default:
            begin
                state_next = PRS_STOP;
            end
        endcase
        if (self_event || op_stop || (bcd_hit && ctrl_reg[CTRL_BCD_STOP]))
        begin
            state_next = PRS_FAULT;
            restart_next = 1'b0;
        end
        else if (!i_master_run_enable && state_reg != PRS_FAULT)
        begin
            state_next = PRS_STOP;
            restart_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= PRS_STOP;
            restart_reg <= 1'b0;
            o_engine_run <= 1'b0;
            o_outputs_enable <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            restart_reg <= restart_next;
            o_engine_run <= (state_next == PRS_RUN) || (state_next == PRS_DRAIN);
            o_outputs_enable <= (state_next == PRS_RUN) || (state_next == PRS_DRAIN);
        end
    end

    assign o_restart_step0 = restart_reg;

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: prescaler gives 10 ms ticks, tick count compared with setting
    always_comb
    begin
        tick = (presc_reg == PRESC_LAST);
        presc_next = tick ? '0 : presc_reg + 1'b1;
        tick_cnt_next = tick_cnt_reg;
        // prescaler keeps running in fault, where it paces the blinking indicator
        if ((!running && state_reg != PRS_FAULT) || i_end_done)
        begin
            presc_next = '0;
        end
        if (!running || i_end_done)
        begin
            tick_cnt_next = '0;
        end
        else if (tick && tick_cnt_reg != WDT_MAX_TICKS)
        begin
            tick_cnt_next = tick_cnt_reg + 1'b1;
        end
        // timeout signal holds until reset
        wdt_to_next = wdt_to_reg | wdt_event;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            presc_reg <= '0;
            tick_cnt_reg <= '0;
            wdt_to_reg <= 1'b0;
        end
        else
        begin
            presc_reg <= presc_next;
            tick_cnt_reg <= tick_cnt_next;
            wdt_to_reg <= wdt_to_next;
        end
    end

    assign o_wdt_timeout = wdt_to_reg;

    ////////////////////////////////////////////////////////////////////////////
    // run indicator: steady in run, blinking after a stop-class fault
    // blink uses the free-running tick only in fault, where the watchdog is idle
    always_comb
    begin
        blink_cnt_next = blink_cnt_reg;
        blink_next = blink_reg;
        if (state_reg != PRS_FAULT)
        begin
            blink_cnt_next = '0;
            // indicator goes dark at once on a fault, then toggles
            blink_next = 1'b0;
        end
        else if (tick)
        begin
            blink_cnt_next = (blink_cnt_reg == LED_BLINK_TICKS) ? '0 : blink_cnt_reg + 1'b1;
            blink_next = (blink_cnt_reg == LED_BLINK_TICKS) ? !blink_reg : blink_reg;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
            o_run_led <= 1'b0;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            o_run_led <= running ? 1'b1 : (state_reg == PRS_FAULT) & blink_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error flags and code; a hardware set wins over a software clear
    assign bus_req = i_avs_read | i_avs_write;
    assign wr_take = i_avs_write && !waitreq_reg;
    assign wr_lane0 = wr_take && i_avs_byteenable[0];

    always_comb
    begin
        diag_error_flag_next = diag_error_flag_reg;
        self_diag_error_flag_next = self_diag_error_flag_reg;
        diag_error_code_next = diag_error_code_reg;
        skip_next = op_skip;
        if (wr_lane0 && i_avs_address == OFS_STATUS)
        begin
            // write one to clear
            if (i_avs_writedata[STAT_DIAG])
            begin
                diag_error_flag_next = 1'b0;
            end
            if (i_avs_writedata[STAT_SELF])
            begin
                self_diag_error_flag_next = 1'b0;
            end
        end
        if (bcd_hit)
        begin
            diag_error_flag_next = 1'b1;
            diag_error_code_next = ERR_BCD_RANGE;
        end
        if (running && i_op_err.valid)
        begin
            diag_error_flag_next = 1'b1;
            diag_error_code_next = i_op_err.code;
        end
        if (self_event)
        begin
            self_diag_error_flag_next = 1'b1;
            diag_error_flag_next = 1'b1;
            diag_error_code_next = !running ? ERR_INIT : (i_hw_fail ? ERR_HW : ERR_WDT);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            diag_error_flag_reg <= 1'b0;
            self_diag_error_flag_reg <= 1'b0;
            diag_error_code_reg <= ERR_NONE;
            skip_reg <= 1'b0;
        end
        else
        begin
            diag_error_flag_reg <= diag_error_flag_next;
            self_diag_error_flag_reg <= self_diag_error_flag_next;
            diag_error_code_reg <= diag_error_code_next;
            skip_reg <= skip_next;
        end
    end

    assign o_skip_step = skip_reg;

    ////////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait state, write and read data at the second edge
    assign status_vec = {wdt_to_reg, self_diag_error_flag_reg, diag_error_flag_reg,
                         state_reg == PRS_FAULT, state_reg == PRS_STOP, running};

    always_comb
    begin
        ctrl_next = ctrl_reg;
        contact_sel_next = contact_sel_reg;
        wdt_set_next = wdt_set_reg;
        waitreq_next = !(bus_req && waitreq_reg);
        rdata_next = '0;
        if (wr_lane0 && i_avs_address == OFS_CTRL)
        begin
            ctrl_next = i_avs_writedata[CTRL_W-1:0];
        end
        if (wr_lane0 && i_avs_address == OFS_CONTACT)
        begin
            contact_sel_next = i_avs_writedata[POINT_W-1:0];
        end
        if (wr_lane0 && i_avs_address == OFS_WDT)
        begin
            if (i_avs_writedata[TICK_W-1:0] < WDT_MIN_TICKS)
            begin
                wdt_set_next = WDT_MIN_TICKS;
            end
            else if (i_avs_writedata[TICK_W-1:0] > WDT_MAX_TICKS)
            begin
                wdt_set_next = WDT_MAX_TICKS;
            end
            else
            begin
                wdt_set_next = i_avs_writedata[TICK_W-1:0];
            end
        end
        if (i_avs_read && waitreq_reg)
        begin
            case (i_avs_address)
                OFS_CTRL: rdata_next = {29'h0, ctrl_reg};
                OFS_CONTACT: rdata_next = {24'h0, contact_sel_reg};
                OFS_WDT: rdata_next = {24'h0, wdt_set_reg};
                OFS_STATUS: rdata_next = {26'h0, status_vec};
                OFS_ERRCODE: rdata_next = {16'h0, diag_error_code_reg};
                default: rdata_next = '0;
            endcase
        end
        else if (!waitreq_reg)
        begin
            rdata_next = rdata_reg;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl_reg <= CTRL_RESET;
            contact_sel_reg <= '0;
            wdt_set_reg <= WDT_DEFAULT_TICKS;
            waitreq_reg <= 1'b1;
            rdata_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            contact_sel_reg <= contact_sel_next;
            wdt_set_reg <= wdt_set_next;
            waitreq_reg <= waitreq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_avs_waitrequest = waitreq_reg;
    assign o_avs_readdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    master_off_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_master_run_enable |=> !o_engine_run)
        else $error("engine still runs with master enable off");

    remote_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_master_run_enable |=> !o_restart_step0)
        else $error("restart issued with master enable off");

    drain_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg == PRS_DRAIN && !i_scan_end && i_master_run_enable && !self_event
         && !op_stop && !bcd_hit) |=> state_reg == PRS_DRAIN)
        else $error("stop taken before scan end");

    restart_step0_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg == PRS_STOP ##1 state_reg == PRS_RUN) |-> o_restart_step0 ##1 !o_restart_step0)
        else $error("return to run without single restart pulse");

    contact_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg == PRS_RUN && remote_stop && i_master_run_enable && !self_event
         && !op_stop && !bcd_hit) |=> state_reg == PRS_DRAIN ##0 o_engine_run)
        else $error("remote stop request not taken");

    release_all_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg == PRS_STOP && remote_stop) |=> state_reg != PRS_RUN)
        else $error("run resumed while a stop source remains");

    stop_outputs_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (state_reg == PRS_STOP || state_reg == PRS_FAULT) |-> !o_outputs_enable && !o_engine_run)
        else $error("outputs enabled while stopped");

    wdt_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        wdt_event |=> o_wdt_timeout && !o_outputs_enable && self_diag_error_flag_reg
        ##1 o_wdt_timeout && !o_run_led)
        else $error("watchdog timeout not handled");

    wdt_restart_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_end_done |=> tick_cnt_reg == '0 && presc_reg == '0)
        else $error("watchdog count not restarted after end");

    force_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (running && i_op_err.valid && i_op_err.force_stop) |=> state_reg == PRS_FAULT && !o_skip_step)
        else $error("forced stop error did not halt");

    skip_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (running && i_op_err.valid && !i_op_err.stop_class && !i_op_err.force_stop
         && !self_event && !i_bcd_overflow) |=> o_skip_step && o_engine_run)
        else $error("continue error did not skip");

    bcd_code_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (bcd_hit && !i_op_err.valid && !self_event) |=> diag_error_code_reg == ERR_BCD_RANGE
        && diag_error_flag_reg)
        else $error("range error code not stored");

    diag_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (diag_error_flag_reg && !(wr_lane0 && i_avs_address == OFS_STATUS)) |=> diag_error_flag_reg)
        else $error("diagnostic flag dropped without clear");

endmodule : prs_top

`default_nettype wire

//--- inc/prs_pkg.sv
// Purpose: shared constants and types for the program run supervisor
// Assumes: 125 MHz system clock, Avalon-MM register slave with byte addresses
// Notes:   error codes other than the range-conversion code are arbitrary values
package prs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned WDT_TICK_MS = 10;
    localparam int unsigned WDT_TICK_CYCLES = CLK_HZ / 1000 * WDT_TICK_MS;
    localparam int unsigned WDT_MIN_MS = 10;
    localparam int unsigned WDT_MAX_MS = 2000;
    localparam int unsigned WDT_DEFAULT_MS = 200;
    localparam int unsigned TICK_W = 8;
    localparam logic [TICK_W-1:0] WDT_MIN_TICKS = TICK_W'(WDT_MIN_MS / WDT_TICK_MS);
    localparam logic [TICK_W-1:0] WDT_MAX_TICKS = TICK_W'(WDT_MAX_MS / WDT_TICK_MS);
    localparam logic [TICK_W-1:0] WDT_DEFAULT_TICKS = TICK_W'(WDT_DEFAULT_MS / WDT_TICK_MS);
    localparam logic [5:0] LED_BLINK_TICKS = 6'h32;

    ////////////////////////////////////////////////////////////////////////////
    // input points usable as remote run contact
    localparam int unsigned NUM_POINTS = 144;
    localparam int unsigned POINT_W = 8;
    localparam logic [POINT_W-1:0] LAST_POINT = 8'h8f;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam int unsigned ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTACT = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_WDT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_ERRCODE = 5'h10;

    // control bits
    localparam int unsigned CTRL_W = 3;
    localparam int unsigned CTRL_HOST_STOP = 0;
    localparam int unsigned CTRL_CONTACT_EN = 1;
    localparam int unsigned CTRL_BCD_STOP = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

    // status bits
    localparam int unsigned STAT_RUN = 0;
    localparam int unsigned STAT_STOPPED = 1;
    localparam int unsigned STAT_FAULT = 2;
    localparam int unsigned STAT_DIAG = 3;
    localparam int unsigned STAT_SELF = 4;
    localparam int unsigned STAT_WDT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // error codes
    localparam int unsigned CODE_W = 16;
    localparam logic [CODE_W-1:0] ERR_NONE = 16'h0000;
    localparam logic [CODE_W-1:0] ERR_BCD_RANGE = 16'h0032;
    localparam logic [CODE_W-1:0] ERR_WDT = 16'h0100;
    localparam logic [CODE_W-1:0] ERR_INIT = 16'h0101;
    localparam logic [CODE_W-1:0] ERR_HW = 16'h0102;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [3:0] {
        PRS_RUN = 4'h1,
        PRS_DRAIN = 4'h2,
        PRS_STOP = 4'h4,
        PRS_FAULT = 4'h8
    } prs_state_e;

    typedef struct packed {
        logic valid;
        logic stop_class;
        logic force_stop;
        logic [CODE_W-1:0] code;
    } prs_err_s;

endpackage : prs_pkg

//--- verif/prs_far_end.sv
// Purpose: far side model, remote run contact and engine scan strobes
// Assumes: controls come from the bench just after rising edges
// Notes:   scans pause when i_scans_on is low, starving the watchdog
`timescale 1ns/1ps
`default_nettype none
module prs_far_end
    import prs_pkg::*;
(
    // clock and control
    input wire logic i_clk_sys,
    input wire logic i_run,
    input wire logic i_scans_on,
    input wire logic [POINT_W-1:0] i_idx,
    input wire logic i_contact_on,
    // engine strobes and points
    output logic o_scan_end,
    output logic o_end_done,
    output logic [NUM_POINTS-1:0] o_points
);
    int cnt = 0;
    initial o_scan_end = 1'b0;
    initial o_end_done = 1'b0;
    // contact on asks stop; only the chosen point moves
    always_comb o_points = NUM_POINTS'(i_contact_on) << i_idx;
    // each scan ends, then end processing follows one cycle later
    always @(posedge i_clk_sys)
    begin
        o_scan_end <= 1'b0;
        o_end_done <= o_scan_end;
        cnt <= (i_run && i_scans_on) ? cnt + 1 : 0;
        if (i_run && i_scans_on && cnt == 5)
        begin
            o_scan_end <= 1'b1;
            cnt <= 0;
        end
    end
endmodule : prs_far_end
`default_nettype wire

//--- verif/tb.sv
// Purpose: self-checking bench for the program run supervisor
// Assumes: short watchdog tick of 4 cycles
// Notes:   watchdog fault is sticky, so a mid-run reset follows that test
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: value mismatch", $time); end end
module tb;
    import prs_pkg::*;
    logic clk = 0, rst_n = 0, master = 1, rd = 0, wr = 0, bcd = 0, scans = 1, con = 0;
    logic se, ed, run, rst0, oen, skip, led, wdt, wreq;
    logic [NUM_POINTS-1:0] pts;
    logic [POINT_W-1:0] idx = 8'h00;
    logic [ADDR_W-1:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    prs_err_s op = '0;
    int num_errors = 0, checked = 0, n_rst = 0, n_skip = 0, exp_skip = 0;
    always #4 clk = ~clk;
    // pulse counters, so one-cycle strobes are never missed
    always @(posedge clk)
    begin
        n_rst <= n_rst + int'(rst0 === 1'b1);
        n_skip <= n_skip + int'(skip === 1'b1);
    end
    prs_far_end u_far (.i_clk_sys(clk), .i_run(run), .i_scans_on(scans), .i_idx(idx),
        .i_contact_on(con), .o_scan_end(se), .o_end_done(ed), .o_points(pts));
    prs_top #(.P_TICK_CYCLES(4)) u_dut (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_master_run_enable(master), .i_input_points(pts), .i_scan_end(se),
        .i_end_done(ed), .i_hw_fail(1'b0), .i_init_fail(1'b0), .i_op_err(op),
        .i_bcd_overflow(bcd), .o_engine_run(run), .o_restart_step0(rst0),
        .o_outputs_enable(oen), .o_skip_step(skip), .o_run_led(led), .o_wdt_timeout(wdt),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // one avalon access; hold until waitrequest is sampled low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge clk);
            wr <= w;
            rd <= !w;
            addr <= a;
            wdata <= d;
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (wreq !== 1'b0 && n < 50);
            q = rdata;
            wr <= 1'b0;
            rd <= 1'b0;
            if (n >= 50)
            begin
                num_errors++;
                give_verdict();
            end
        end
    endtask : bus
    // bounded wait for the run level
    task automatic wait_run(input logic v);
        int n;
        begin
            n = 0;
            while (run !== v && n < 200)
            begin
                @(posedge clk);
                n++;
            end
            `CHK(run, v)
            if (n >= 200)
                give_verdict();
        end
    endtask : wait_run
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(28));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(1'b1);
        bus(1'b0, OFS_WDT, 32'h0);
        `CHK(q, 32'h14)
        // host stop must let the current scan finish
        scans <= 1'b0;
        bus(1'b1, OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(run, 1'b1)
        scans <= 1'b1;
        wait_run(1'b0);
        `CHK(oen, 1'b0)
        master <= 1'b0;
        bus(1'b1, OFS_CTRL, 32'h0);
        repeat (5) @(posedge clk);
        `CHK(run, 1'b0)
        master <= 1'b1;
        wait_run(1'b1);
        @(posedge clk);
        `CHK(n_rst, 2)
        $display("test run stop done");
        // contact at a random point plus host: both must withdraw
        idx <= POINT_W'($urandom % NUM_POINTS);
        @(posedge clk);
        bus(1'b1, OFS_CONTACT, 32'(idx));
        bus(1'b1, OFS_CTRL, 32'h2);
        con <= 1'b1;
        wait_run(1'b0);
        bus(1'b1, OFS_CTRL, 32'h3);
        con <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(run, 1'b0)
        bus(1'b1, OFS_CTRL, 32'h2);
        wait_run(1'b1);
        $display("test remote sources done");
        // continue-class errors skip and record a code
        bcd <= 1'b1;
        @(posedge clk);
        bcd <= 1'b0;
        exp_skip++;
        bus(1'b0, OFS_ERRCODE, 32'h0);
        `CHK(q, 32'h32)
        `CHK(n_skip, exp_skip)
        op <= '{valid: 1'b1, stop_class: 1'b0, force_stop: 1'b0, code: 16'h0007};
        @(posedge clk);
        op <= '0;
        exp_skip++;
        bus(1'b0, OFS_ERRCODE, 32'h0);
        `CHK(q, 32'h7)
        `CHK(n_skip, exp_skip)
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[STAT_DIAG], 1'b1)
        `CHK(run, 1'b1)
        $display("test op errors done");
        // starve the watchdog with a short setting
        bus(1'b1, OFS_WDT, 32'h2);
        scans <= 1'b0;
        wait_run(1'b0);
        `CHK(wdt, 1'b1)
        @(posedge clk);
        `CHK(led, 1'b0)
        repeat (210) @(posedge clk);
        `CHK(led, 1'b1)
        `CHK(oen, 1'b0)
        bus(1'b0, OFS_ERRCODE, 32'h0);
        `CHK(q, 32'h100)
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[STAT_SELF], 1'b1)
        $display("test watchdog done");
        // reset in mid-run clears the fault; a forced-stop error halts at once
        rst_n <= 1'b0;
        scans <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wait_run(1'b1);
        `CHK(wdt, 1'b0)
        op <= '{valid: 1'b1, stop_class: 1'b0, force_stop: 1'b1, code: 16'h0009};
        @(posedge clk);
        op <= '0;
        wait_run(1'b0);
        `CHK(n_skip, exp_skip)
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK(q[STAT_FAULT], 1'b1)
        bus(1'b0, OFS_ERRCODE, 32'h0);
        `CHK(q, 32'h9)
        $display("test forced stop done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
